// File: include/cb_status_defs.svh
/*
 * offsets, field positions, reset value and fixed field codes of the
 * cardbus side status register. assumes inclusion by bare name.
 */
`ifndef CB_STATUS_DEFS_SVH
`define CB_STATUS_DEFS_SVH

`define CBS_OFFSET 8'h16
`define CBS_RESET 16'h0200
`define CBS_BIT_DET_PAR 15
`define CBS_BIT_SIG_SERR 14
`define CBS_BIT_RCV_MABT 13
`define CBS_BIT_RCV_TABT 12
`define CBS_BIT_SIG_TABT 11
`define CBS_TIMING_HI 10
`define CBS_TIMING_LO 9
`define CBS_BIT_DATA_PAR 8
`define CBS_BIT_FBB 7
`define CBS_TIMING_MEDIUM 2'h1
`define CBS_NUM_SOCKETS 2

`endif

// File: include/cb_status_pkg.sv
/*
 * types shared by the cardbus side status register.
 * assumes nothing of its surroundings.
 */
package cb_status_pkg;
    typedef logic [15:0] status_word_t;
    typedef logic [5:0] sticky_flags_t;
endpackage : cb_status_pkg

// File: rtl/cardbus_secondary_status.sv
/*
 * per-socket cardbus side status register: sticky error flags set by
 * bus events, cleared by writing ones through configuration space.
 * assumes the config decoder supplies an offset, byte enables and a
 * one-cycle write strobe selecting one socket function.
 */
`timescale 1ns/1ps
`include "cb_status_defs.svh"

// Contract
// - writing one clears a sticky flag; writing zero leaves it
// - each socket function keeps its own independent copy
// - any address or data parity error sets detected parity flag
// - card asserting system error sets the signalled system error flag
// - bridge never drives the card system error line, only monitors it
// - master abort on a bridge-initiated cycle sets received master abort
// - target abort on a bridge-initiated cycle sets received target abort
// - bridge terminating as target with abort sets signalled target abort
// - select timing field reads constant medium code, writes ignored
// - data parity flag needs perr, bridge master and response enable
// - fast back-to-back capable bit always reads zero
module cardbus_secondary_status (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [7:0] CFG_OFFSET,
    input wire logic CFG_FUNC,
    input wire logic CFG_WR,
    input wire logic [1:0] CFG_BE,
    input wire logic [15:0] CFG_WDATA,
    output logic [15:0] CFG_RDATA,
    input wire logic [1:0] ADDR_PARITY_ERR,
    input wire logic [1:0] DATA_PARITY_ERR,
    input wire logic [1:0] CSERR_N,
    input wire logic [1:0] MASTER_ABORT_RCVD,
    input wire logic [1:0] TARGET_ABORT_RCVD,
    input wire logic [1:0] TARGET_ABORT_SIGNALLED,
    input wire logic [1:0] CPERR_N,
    input wire logic [1:0] BRIDGE_IS_MASTER,
    input wire logic [1:0] PERR_RESPONSE_EN,
    output logic [1:0] CSERR_N_OUT,
    output logic [1:0] CSERR_N_OE_N
);

    // ------------------------------------------------------------
    // register select
    // ------------------------------------------------------------
    function automatic logic hits_status(input logic [7:0] off);
        hits_status = (off == `CBS_OFFSET);
    endfunction : hits_status

    // flags held as {det_par, sig_serr, rcv_mabt, rcv_tabt, sig_tabt, data_par}
    cb_status_pkg::sticky_flags_t flags_ff [`CBS_NUM_SOCKETS];
    cb_status_pkg::sticky_flags_t set_ev [`CBS_NUM_SOCKETS];
    cb_status_pkg::sticky_flags_t clr_ev [`CBS_NUM_SOCKETS];

    // ------------------------------------------------------------
    // system error line: input only
    // ------------------------------------------------------------
    // the card owns this line; keep our driver parked so it can never fight
    assign CSERR_N_OUT = 2'h3;
    assign CSERR_N_OE_N = 2'h3;

    // ------------------------------------------------------------
    // per-socket flag storage
    // ------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < `CBS_NUM_SOCKETS; s = s + 1) begin : g_sock
            logic wr_hit;
            assign wr_hit = CFG_WR && hits_status(CFG_OFFSET) && (CFG_FUNC == 1'(s));
            assign set_ev[s] = {
                ADDR_PARITY_ERR[s] | DATA_PARITY_ERR[s],
                ~CSERR_N[s],
                MASTER_ABORT_RCVD[s],
                TARGET_ABORT_RCVD[s],
                TARGET_ABORT_SIGNALLED[s],
                ~CPERR_N[s] & BRIDGE_IS_MASTER[s] & PERR_RESPONSE_EN[s]
            };
            // high byte lane carries bits 15..11 and bit 8
            assign clr_ev[s] = wr_hit ? {CFG_WDATA[15:11] & {5{CFG_BE[1]}},
                                         CFG_WDATA[`CBS_BIT_DATA_PAR] & CFG_BE[1]}
                                      : 6'h00;
            // a set in the same cycle as a clear wins so no event is lost
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    flags_ff[s] <= 6'h00;
                end else begin
                    flags_ff[s] <= (flags_ff[s] & ~clr_ev[s]) | set_ev[s];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    cb_status_pkg::status_word_t nxt_rdata;
    cb_status_pkg::status_word_t rdata_ff;
    cb_status_pkg::sticky_flags_t sel_flags;

    always_comb begin
        sel_flags = flags_ff[CFG_FUNC];
        nxt_rdata = 16'h0000;
        if (hits_status(CFG_OFFSET)) begin
            nxt_rdata[15:11] = sel_flags[5:1];
            nxt_rdata[`CBS_TIMING_HI:`CBS_TIMING_LO] = `CBS_TIMING_MEDIUM;
            nxt_rdata[`CBS_BIT_DATA_PAR] = sel_flags[0];
            nxt_rdata[`CBS_BIT_FBB] = 1'b0;
            nxt_rdata[6:0] = 7'h00;
        end else begin
            nxt_rdata = 16'h0000;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign CFG_RDATA = rdata_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic hit_now;
    assign hit_now = hits_status(CFG_OFFSET);
    // clearing write per socket, decoded apart from the flag logic
    logic [1:0] wr_sock;
    assign wr_sock[0] = CFG_WR && hit_now && CFG_BE[1] && !CFG_FUNC;
    assign wr_sock[1] = CFG_WR && hit_now && CFG_BE[1] && CFG_FUNC;

    clear_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (CFG_WR && hit_now && CFG_BE[1] && CFG_WDATA[15] && !CFG_FUNC
         && !ADDR_PARITY_ERR[0] && !DATA_PARITY_ERR[0]) |=> !flags_ff[0][5])
        else $error("parity flag not cleared by write of one");
    keep_zero_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[0][4] && !(CFG_WR && hit_now && !CFG_FUNC && CFG_BE[1]
         && CFG_WDATA[14])) |=> flags_ff[0][4])
        else $error("system error flag lost without a clear");
    socket_split_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[1][3] && !MASTER_ABORT_RCVD[1] && MASTER_ABORT_RCVD[0]) |=> !flags_ff[1][3])
        else $error("socket 0 abort reached socket 1");
    det_parity_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        ADDR_PARITY_ERR[1] |=> flags_ff[1][5])
        else $error("address parity error not recorded");
    serr_set_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !CSERR_N[0] |=> flags_ff[0][4])
        else $error("card system error not recorded");
    serr_parked_a: assert property (@(posedge CORE_CLK) CSERR_N_OE_N == 2'h3)
        else $error("system error line driven");
    abort_set_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        MASTER_ABORT_RCVD[0] |=> flags_ff[0][3])
        else $error("master abort not recorded");
    tabt_rcv_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TARGET_ABORT_RCVD[1] |=> flags_ff[1][2])
        else $error("received target abort not recorded");
    tabt_sig_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TARGET_ABORT_SIGNALLED[0] |=> flags_ff[0][1])
        else $error("signalled target abort not recorded");
    timing_const_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        hit_now |=> CFG_RDATA[10:9] == 2'h1)
        else $error("select timing field wrong");
    dpar_gate_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[0][0] && !PERR_RESPONSE_EN[0]) |=> !flags_ff[0][0])
        else $error("data parity set without response enable");
    fbb_zero_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CFG_RDATA[7:0] == 8'h00)
        else $error("low bits of status not zero");

    // ------------------------------------------------------------
    // set paths on both sockets
    // ------------------------------------------------------------
    addr_par_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        ADDR_PARITY_ERR[0] |=> flags_ff[0][5])
        else $error("address parity error on socket 0 not recorded");
    data_par_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        DATA_PARITY_ERR[0] |=> flags_ff[0][5])
        else $error("data phase parity error on socket 0 not recorded");
    dpe_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        DATA_PARITY_ERR[1] |=> flags_ff[1][5])
        else $error("data phase parity error on socket 1 not recorded");
    serr_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !CSERR_N[1] |=> flags_ff[1][4])
        else $error("card system error on socket 1 not recorded");
    abort_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        MASTER_ABORT_RCVD[1] |=> flags_ff[1][3])
        else $error("master abort on socket 1 not recorded");
    tabt_zero_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TARGET_ABORT_RCVD[0] |=> flags_ff[0][2])
        else $error("received target abort on socket 0 not recorded");
    tsig_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        TARGET_ABORT_SIGNALLED[1] |=> flags_ff[1][1])
        else $error("signalled target abort on socket 1 not recorded");
    dpar_set_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!CPERR_N[0] && BRIDGE_IS_MASTER[0] && PERR_RESPONSE_EN[0]) |=> flags_ff[0][0])
        else $error("data parity error on socket 0 not recorded");
    dpar_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!CPERR_N[1] && BRIDGE_IS_MASTER[1] && PERR_RESPONSE_EN[1]) |=> flags_ff[1][0])
        else $error("data parity error on socket 1 not recorded");

    // ------------------------------------------------------------
    // data parity gating
    // ------------------------------------------------------------
    dpar_master_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[1][0] && !BRIDGE_IS_MASTER[1]) |=> !flags_ff[1][0])
        else $error("data parity set while not bus master");
    dpar_perr_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[0][0] && CPERR_N[0]) |=> !flags_ff[0][0])
        else $error("data parity set without parity error line");
    dpar_enable_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[1][0] && !PERR_RESPONSE_EN[1]) |=> !flags_ff[1][0])
        else $error("data parity set on socket 1 without response enable");

    // ------------------------------------------------------------
    // write one to clear, zero and other offsets leave flags alone
    // ------------------------------------------------------------
    clear_par1_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[1] && CFG_WDATA[15] && !ADDR_PARITY_ERR[1] && !DATA_PARITY_ERR[1])
        |=> !flags_ff[1][5])
        else $error("socket 1 parity flag not cleared by write of one");
    clear_serr_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[1] && CFG_WDATA[14] && CSERR_N[1]) |=> !flags_ff[1][4])
        else $error("socket 1 system error flag not cleared");
    clear_serr0_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[0] && CFG_WDATA[14] && CSERR_N[0]) |=> !flags_ff[0][4])
        else $error("socket 0 system error flag not cleared");
    clear_mabt_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[0] && CFG_WDATA[13] && !MASTER_ABORT_RCVD[0]) |=> !flags_ff[0][3])
        else $error("socket 0 master abort flag not cleared");
    clear_mabt1_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[1] && CFG_WDATA[13] && !MASTER_ABORT_RCVD[1]) |=> !flags_ff[1][3])
        else $error("socket 1 master abort flag not cleared");
    clear_rtabt_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[0] && CFG_WDATA[12] && !TARGET_ABORT_RCVD[0]) |=> !flags_ff[0][2])
        else $error("socket 0 received target abort flag not cleared");
    clear_rtabt1_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[1] && CFG_WDATA[12] && !TARGET_ABORT_RCVD[1]) |=> !flags_ff[1][2])
        else $error("socket 1 received target abort flag not cleared");
    clear_stabt_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[1] && CFG_WDATA[11] && !TARGET_ABORT_SIGNALLED[1]) |=> !flags_ff[1][1])
        else $error("socket 1 signalled target abort flag not cleared");
    clear_stabt0_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[0] && CFG_WDATA[11] && !TARGET_ABORT_SIGNALLED[0]) |=> !flags_ff[0][1])
        else $error("socket 0 signalled target abort flag not cleared");
    clear_dpar_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[1] && CFG_WDATA[8] && CPERR_N[1]) |=> !flags_ff[1][0])
        else $error("socket 1 data parity flag not cleared");
    clear_dpar0_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (wr_sock[0] && CFG_WDATA[8] && CPERR_N[0]) |=> !flags_ff[0][0])
        else $error("socket 0 data parity flag not cleared");
    hold_high_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[1][5] && !(wr_sock[1] && CFG_WDATA[15])) |=> flags_ff[1][5])
        else $error("socket 1 parity flag lost without a clear");
    hold_dpar_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[0][0] && !(wr_sock[0] && CFG_WDATA[8])) |=> flags_ff[0][0])
        else $error("socket 0 data parity flag lost without a clear");
    zero_keep_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[1][1] && !(wr_sock[1] && CFG_WDATA[11])) |=> flags_ff[1][1])
        else $error("socket 1 signalled abort flag lost without a clear");
    be_gate_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[0][3] && !CFG_BE[1]) |=> flags_ff[0][3])
        else $error("flag cleared with high byte lane disabled");
    off_ignore_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[0][2] && !hit_now) |=> flags_ff[0][2])
        else $error("flag cleared by access to another offset");
    set_wins_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (TARGET_ABORT_RCVD[1] && wr_sock[1] && CFG_WDATA[12]) |=> flags_ff[1][2])
        else $error("event lost to a clear in the same cycle");

    // ------------------------------------------------------------
    // socket separation and read path
    // ------------------------------------------------------------
    split_back_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[0][1] && !TARGET_ABORT_SIGNALLED[0] && TARGET_ABORT_SIGNALLED[1])
        |=> !flags_ff[0][1])
        else $error("socket 1 abort reached socket 0");
    write_split_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[1][3] && CFG_WR && !CFG_FUNC) |=> flags_ff[1][3])
        else $error("write to socket 0 cleared socket 1");
    write_cross_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (flags_ff[0][4] && CFG_WR && CFG_FUNC) |=> flags_ff[0][4])
        else $error("write to socket 1 cleared socket 0");
    serr_split_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (!flags_ff[1][4] && CSERR_N[1] && !CSERR_N[0]) |=> !flags_ff[1][4])
        else $error("socket 0 system error reached socket 1");
    read_zero_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (hit_now && !CFG_FUNC) |=> CFG_RDATA[15:11] == $past(flags_ff[0][5:1]))
        else $error("read of socket 0 shows the wrong copy");
    read_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (hit_now && CFG_FUNC) |=> CFG_RDATA[8] == $past(flags_ff[1][0]))
        else $error("read of socket 1 shows the wrong copy");

    // ------------------------------------------------------------
    // fixed fields and the parked system error driver
    // ------------------------------------------------------------
    fbb_bit_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        hit_now |=> !CFG_RDATA[7])
        else $error("fast back-to-back bit reads one");
    low_bits_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        hit_now |=> CFG_RDATA[6:0] == 7'h00)
        else $error("reserved low bits not zero");
    timing_one_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (hit_now && CFG_FUNC) |=> CFG_RDATA[10:9] == 2'h1)
        else $error("select timing field wrong on socket 1");
    serr_out_a: assert property (@(posedge CORE_CLK) CSERR_N_OUT == 2'h3)
        else $error("system error output value not parked high");

    c_clear: cover property (@(posedge CORE_CLK) CFG_WR && hit_now && CFG_WDATA[15]);
    c_dpar: cover property (@(posedge CORE_CLK) flags_ff[1][0]);
    c_race: cover property (@(posedge CORE_CLK) CFG_WR && hit_now && MASTER_ABORT_RCVD[0]);
    c_set_wins: cover property (@(posedge CORE_CLK)
        TARGET_ABORT_RCVD[1] && wr_sock[1] && CFG_WDATA[12]);
    c_reset_mid: cover property (@(posedge CORE_CLK) RESET && flags_ff[1][5]);

endmodule : cardbus_secondary_status

// File: tb/cardbus_card_model.sv
/* card on the secondary bus: system error and data parity error lines.
 * assumes the bench commands each line at the falling clock edge. */
`timescale 1ns/1ps
module cardbus_card_model (
    input wire logic [1:0] serr_req,
    input wire logic [1:0] perr_req,
    input wire logic [1:0] bridge_serr_n,
    input wire logic [1:0] bridge_serr_oe_n,
    output logic [1:0] cserr_n,
    output logic [1:0] cperr_n
);
    // ------------------------------------------------
    // wired lines
    // ------------------------------------------------
    // open drain with pull-up: a bridge that drove would show up as a low
    assign cserr_n = ~serr_req & (bridge_serr_oe_n | bridge_serr_n);
    assign cperr_n = ~perr_req;
endmodule : cardbus_card_model

// File: tb/test_cardbus_secondary_status.sv
/* bench for the per-socket status register: events, clears, fixed bits.
 * assumes a registered read one cycle after offset and function. */
`timescale 1ns/1ps
module test_cardbus_secondary_status;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en = 1'b0;
    logic func = 1'b0;
    logic [7:0] off = 8'h16;
    logic [1:0] be = 2'h2;
    logic [15:0] wd = 16'h0;
    logic [1:0] ev [0:6] = '{default: 2'h0};
    logic [1:0] mst = 2'h3;
    logic [1:0] pen = 2'h3;
    logic [15:0] rd;
    logic [1:0] so, soe, sn, pn;
    int errors = 0;
    int samples_checked = 0;
    localparam logic [15:0] BT [0:6] = '{16'h8000, 16'h8000, 16'h2000, 16'h1000,
        16'h0800, 16'h4000, 16'h0100};
    // ------------------------------------------------
    // environment
    // ------------------------------------------------
    always #12.5 clk = ~clk;
    cardbus_card_model card_u (.serr_req(ev[5]), .perr_req(ev[6]), .bridge_serr_n(so),
        .bridge_serr_oe_n(soe), .cserr_n(sn), .cperr_n(pn));
    cardbus_secondary_status dut_u (.CORE_CLK(clk), .RESET(rst), .CFG_OFFSET(off),
        .CFG_FUNC(func), .CFG_WR(wr_en), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rd),
        .ADDR_PARITY_ERR(ev[0]), .DATA_PARITY_ERR(ev[1]), .CSERR_N(sn),
        .MASTER_ABORT_RCVD(ev[2]), .TARGET_ABORT_RCVD(ev[3]),
        .TARGET_ABORT_SIGNALLED(ev[4]), .CPERR_N(pn), .BRIDGE_IS_MASTER(mst),
        .PERR_RESPONSE_EN(pen), .CSERR_N_OUT(so), .CSERR_N_OE_N(soe));
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // every task is entered just after a falling edge
    task automatic rdchk(input logic f, input logic [7:0] o, input logic [15:0] exp);
        func = f;
        off = o;
        @(negedge clk);
        check(rd, exp);
    endtask : rdchk
    task automatic wr(input logic f, input logic [15:0] d, input logic [1:0] b);
        func = f;
        off = 8'h16;
        wd = d;
        be = b;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
    task automatic pulse(input int k, input int s);
        ev[k][s] = 1'b1;
        @(negedge clk);
        ev[k][s] = 1'b0;
    endtask : pulse
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        #1000000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rdchk(1'b0, 8'h16, 16'h0200);
        rdchk(1'b1, 8'h14, 16'h0000);
        check({14'h0, soe}, 16'h0003);
        check({14'h0, so}, 16'h0003);
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 7; k++) begin
                pulse(k, s);
                rdchk(s[0], 8'h16, 16'h0200 | BT[k]);
                rdchk(s == 0, 8'h16, 16'h0200);
                wr(s[0], ~BT[k], 2'h2);
                rdchk(s[0], 8'h16, 16'h0200 | BT[k]);
                wr(s[0], BT[k], 2'h2);
                rdchk(s[0], 8'h16, 16'h0200);
            end
        end
        pulse(2, 0);
        wr(1'b0, 16'hffff, 2'h1);
        rdchk(1'b0, 8'h16, 16'h2200);
        wr(1'b0, 16'hffff, 2'h3);
        rdchk(1'b0, 8'h16, 16'h0200);
        mst = 2'h0;
        pulse(6, 0);
        rdchk(1'b0, 8'h16, 16'h0200);
        mst = 2'h3;
        pen = 2'h0;
        pulse(6, 1);
        rdchk(1'b1, 8'h16, 16'h0200);
        ev[3][1] = 1'b1;
        wr(1'b1, 16'h1000, 2'h2);
        ev[3][1] = 1'b0;
        rdchk(1'b1, 8'h16, 16'h1200);
        wr(1'b1, 16'h1000, 2'h2);
        rdchk(1'b1, 8'h16, 16'h0200);
        pulse(0, 1);
        rdchk(1'b1, 8'h16, 16'h8200);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rdchk(1'b1, 8'h16, 16'h0200);
        complete_run();
    end
endmodule : test_cardbus_secondary_status
